// ===== src/tick_timer_pkg.sv
package tick_timer_pkg;

    // =====================================================
    // Widths
    localparam int unsigned COUNT_W = 24;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;

    // =====================================================
    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RELOAD      = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CURRENT     = 8'h08;

    // =====================================================
    // Control and status fields
    localparam int unsigned CSR_ENABLE_BIT = 0;
    localparam int unsigned CSR_WRAP_BIT   = 16;

    // =====================================================
    // Reset values and constants
    localparam logic [COUNT_W-1:0] COUNT_ZERO   = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_ONE    = 24'h000001;
    localparam logic [COUNT_W-1:0] RELOAD_RESET = 24'h000000;
    localparam logic [COUNT_W-1:0] CURRENT_INIT = 24'h000000;
    localparam logic [DATA_W-1:0]  DATA_ZERO    = 32'h00000000;

    // =====================================================
    // Register bus request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    // Timer state seen by the read port
    typedef struct packed {
        logic               enable;
        logic               wrap_flag;
        logic [COUNT_W-1:0] reload;
        logic [COUNT_W-1:0] current;
    } tick_view_t;

    // Counter action for one cycle
    typedef enum logic [1:0] {
        ACT_HOLD   = 2'b00,
        ACT_DEC    = 2'b01,
        ACT_RELOAD = 2'b10,
        ACT_CLEAR  = 2'b11
    } count_act_t;

endpackage

// ===== src/tick_read_port.sv
`timescale 1ns/1ps
`default_nettype none

module tick_read_port
    import tick_timer_pkg::*;
(
    // Clock and reset
    input  wire logic                i_core_clk,
    input  wire logic                i_nrst,
    // Read request
    input  wire logic                i_rd,
    input  wire logic [ADDR_W-1:0]   i_addr,
    input  wire tick_view_t          i_view,
    // Read answer
    output logic      [DATA_W-1:0]   o_rdata
);

    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    // =====================================================
    // Read mux; data stand only in the cycle after the strobe
    always_comb begin
        rdata_d = DATA_ZERO;
        if (i_rd) begin
            case (i_addr)
                OFS_CTRL_STATUS: begin
                    rdata_d[CSR_ENABLE_BIT] = i_view.enable;
                    rdata_d[CSR_WRAP_BIT]   = i_view.wrap_flag;
                end
                OFS_RELOAD: begin
                    rdata_d[COUNT_W-1:0] = i_view.reload;
                end
                OFS_CURRENT: begin
                    rdata_d[COUNT_W-1:0] = i_view.current;
                end
                default: begin
                    rdata_d = DATA_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q <= DATA_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

endmodule

`default_nettype wire

// ===== src/system_tick_timer.sv
// Function
// - 24-bit down counter wrapping at zero
// - Enabled: decrement by one per clock
// - After zero, load reload value next clock
// - Set wrap flag on transition to zero
// - Reading control/status clears wrap flag
// - Current value undefined at reset
// - Any current-value write clears counter
// - Zero reload keeps counter at zero
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module system_tick_timer
    import tick_timer_pkg::*;
(
    // Clock and reset
    input  wire logic                i_core_clk,
    input  wire logic                i_nrst,
    // Register port
    input  wire bus_req_t            i_bus,
    output logic      [DATA_W-1:0]   o_rdata,
    // Timer status
    output logic                     o_enabled,
    output logic                     o_wrap_flag,
    output logic                     o_wrap_pulse,
    output logic      [COUNT_W-1:0]  o_current
);

    // =====================================================
    // State
    logic               enable_q;
    logic               enable_d;
    logic [COUNT_W-1:0] reload_q;
    logic [COUNT_W-1:0] reload_d;
    logic [COUNT_W-1:0] current_q;
    logic [COUNT_W-1:0] current_d;
    logic               wrap_flag_q;
    logic               wrap_flag_d;
    logic               wrap_pulse_q;
    logic               wrap_pulse_d;
    count_act_t         act;
    logic               hit_zero;
    tick_view_t         view;
    logic               wrap_set;
    logic               wrap_clr;

    // =====================================================
    // Register decode
    logic wr_ctrl;
    logic wr_reload;
    logic wr_current;
    logic rd_ctrl;

    // Unmapped offsets decode to nothing, so stray writes are dropped
    always_comb begin
        wr_ctrl    = 1'h0;
        wr_reload  = 1'h0;
        wr_current = 1'h0;
        rd_ctrl    = 1'h0;
        case (i_bus.addr)
            OFS_CTRL_STATUS: begin
                wr_ctrl = i_bus.wr;
                rd_ctrl = i_bus.rd;
            end
            OFS_RELOAD: begin
                wr_reload = i_bus.wr;
            end
            OFS_CURRENT: begin
                wr_current = i_bus.wr;
            end
            default: begin
                wr_ctrl = 1'h0;
            end
        endcase
    end

    // =====================================================
    // Enable bit; takes effect on the clock after the write
    always_comb begin
        enable_d = enable_q;
        if (wr_ctrl) begin
            enable_d = i_bus.wdata[CSR_ENABLE_BIT];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            enable_q <= 1'h0;
        end else begin
            enable_q <= enable_d;
        end
    end

    // =====================================================
    // Reload value; a new value is used at the next wrap, not at once
    always_comb begin
        reload_d = reload_q;
        if (wr_reload) begin
            reload_d = i_bus.wdata[COUNT_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            reload_q <= RELOAD_RESET;
        end else begin
            reload_q <= reload_d;
        end
    end

    // =====================================================
    // Counter action; a software clear beats counting
    always_comb begin
        if (wr_current) begin
            act = ACT_CLEAR;
        end else if (!enable_q) begin
            act = ACT_HOLD;
        end else if (current_q == COUNT_ZERO) begin
            act = ACT_RELOAD;
        end else begin
            act = ACT_DEC;
        end
    end

    // Only a decrement from one is a transition to zero;
    // reloading zero or clearing does not count as one.
    always_comb begin
        hit_zero = (act == ACT_DEC) && (current_q == COUNT_ONE);
    end

    always_comb begin
        case (act)
            ACT_HOLD: begin
                current_d = current_q;
            end
            ACT_DEC: begin
                current_d = current_q - COUNT_ONE;
            end
            ACT_RELOAD: begin
                // Zero reload leaves the counter parked at zero
                current_d = reload_q;
            end
            ACT_CLEAR: begin
                current_d = COUNT_ZERO;
            end
            default: begin
                current_d = current_q;
            end
        endcase
    end

    // Reset value serves simulation only; software must clear the
    // counter before enabling, since its contents are undefined
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            current_q <= CURRENT_INIT;
        end else begin
            current_q <= current_d;
        end
    end

    // =====================================================
    // Wrap events; a read landing on a wrap must not lose the wrap
    always_comb begin
        wrap_set = hit_zero;
        wrap_clr = rd_ctrl && !hit_zero;
    end

    // =====================================================
    // Wrap flag: a new wrap beats a clearing read
    always_comb begin
        wrap_flag_d = wrap_flag_q;
        if (wrap_clr) begin
            wrap_flag_d = 1'h0;
        end
        if (wrap_set) begin
            wrap_flag_d = 1'h1;
        end
        wrap_pulse_d = wrap_set;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wrap_flag_q  <= 1'h0;
            wrap_pulse_q <= 1'h0;
        end else begin
            wrap_flag_q  <= wrap_flag_d;
            wrap_pulse_q <= wrap_pulse_d;
        end
    end

    // =====================================================
    // Read path; the flag value returned is the one before clearing
    always_comb begin
        view.enable    = enable_q;
        view.wrap_flag = wrap_flag_q;
        view.reload    = reload_q;
        view.current   = current_q;
    end

    tick_read_port u_read_port (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_rd       (i_bus.rd),
        .i_addr     (i_bus.addr),
        .i_view     (view),
        .o_rdata    (o_rdata)
    );

    // =====================================================
    // Status outputs
    // Pulse is a status strobe only; any interrupt is wired outside
    assign o_enabled    = enable_q;
    assign o_wrap_flag  = wrap_flag_q;
    assign o_wrap_pulse = wrap_pulse_q;
    assign o_current    = current_q;

endmodule

`default_nettype wire

// ===== dv/tick_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tick_timer_asserts
    import tick_timer_pkg::*;
(
    // Clock and reset
    input wire logic               i_core_clk,
    input wire logic               i_nrst,
    // Watched ports
    input wire bus_req_t           i_bus,
    input wire logic [DATA_W-1:0]  o_rdata,
    input wire logic               o_enabled,
    input wire logic               o_wrap_flag,
    input wire logic               o_wrap_pulse,
    input wire logic [COUNT_W-1:0] o_current
);
    // ====================
    // Reload shadow
    logic [COUNT_W-1:0] reload_q;
    logic               cur_wr;
    assign cur_wr = i_bus.wr && i_bus.addr == OFS_CURRENT;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) reload_q <= RELOAD_RESET;
        else if (i_bus.wr && i_bus.addr == OFS_RELOAD) reload_q <= i_bus.wdata[COUNT_W-1:0];
    end
    // ====================
    // Properties
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_last_tick;
        o_enabled && o_current == COUNT_ONE && !cur_wr;
    endsequence
    a_count_down: assert property (
        o_enabled && o_current != COUNT_ZERO && !cur_wr |=> o_current == $past(o_current) - COUNT_ONE)
        else $error("count did not step down");
    a_reload_load: assert property (
        o_enabled && o_current == COUNT_ZERO && !i_bus.wr |=> o_current == reload_q)
        else $error("reload not taken");
    a_wrap_set: assert property (
        s_last_tick |=> o_wrap_flag && o_wrap_pulse && o_current == COUNT_ZERO)
        else $error("wrap not flagged");
    a_read_clear: assert property (
        i_bus.rd && i_bus.addr == OFS_CTRL_STATUS && !(o_enabled && o_current == COUNT_ONE) |=> !o_wrap_flag)
        else $error("flag kept after read");
    a_write_clear: assert property (cur_wr |=> o_current == COUNT_ZERO)
        else $error("counter not cleared");
    a_idle_hold: assert property (
        !o_enabled && !cur_wr |=> $stable(o_current) && !o_wrap_pulse && !$rose(o_wrap_flag))
        else $error("disabled counter moved");
    a_rdata_quiet: assert property (!i_bus.rd |=> o_rdata == DATA_ZERO)
        else $error("read data without read");
    a_csr_view: assert property (
        i_bus.rd && i_bus.addr == OFS_CTRL_STATUS |=>
        o_rdata == {15'h0000, $past(o_wrap_flag), 15'h0000, $past(o_enabled)})
        else $error("status word wrong");
    a_park_quiet: assert property (
        o_enabled && o_current == COUNT_ZERO |=> !o_wrap_pulse && !$rose(o_wrap_flag))
        else $error("wrap flagged on reload");
    a_pulse_single: assert property (o_wrap_pulse |=> !o_wrap_pulse)
        else $error("wrap pulse too long");
endmodule
bind system_tick_timer tick_timer_asserts u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_bus(i_bus),
    .o_rdata(o_rdata), .o_enabled(o_enabled), .o_wrap_flag(o_wrap_flag), .o_wrap_pulse(o_wrap_pulse),
    .o_current(o_current));
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import tick_timer_pkg::*;
;
    logic               i_core_clk;
    logic               i_nrst;
    bus_req_t           bus;
    logic [DATA_W-1:0]  rdata;
    logic               en;
    logic               flag;
    logic               pulse;
    logic [COUNT_W-1:0] cur;
    logic [DATA_W-1:0]  exp_q[$];
    logic               pend;
    logic [31:0]        seed;
    logic [COUNT_W-1:0] r;
    int                 n_errors;
    int                 n_compared;
    int                 n;
    int                 k;

    system_tick_timer dut_u (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata),
        .o_enabled(en), .o_wrap_flag(flag), .o_wrap_pulse(pulse), .o_current(cur));

    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    // ====================
    // Tasks
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic check(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic put(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_core_clk);
        bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        exp_q.push_back(e);
        put(1'b0, a, DATA_ZERO);
    endtask
    task automatic idle(input int c);
        repeat (c) begin
            @(posedge i_core_clk);
            bus <= '0;
        end
    endtask
    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ====================
    // Read data watcher, one cycle after each read strobe
    always @(posedge i_core_clk) begin
        #1;
        if (pend) check("rdata", exp_q.pop_front(), rdata);
        pend = bus.rd;
    end

    // ====================
    // Stimulus
    initial begin
        bus = '0;
        i_nrst = 1'b0;
        pend = 1'b0;
        seed = 32'h00000004;
        n_errors = 0;
        n_compared = 0;
        repeat (4) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        rd(OFS_CTRL_STATUS, DATA_ZERO);
        put(1'b1, 8'h0C, 32'hFFFFFFFF);
        rd(8'h0C, DATA_ZERO);
        rd(OFS_RELOAD, DATA_ZERO);
        // Period of four; the reads straddle the next wrap
        put(1'b1, OFS_RELOAD, 32'h00000003);
        put(1'b1, OFS_CURRENT, 32'hFFFFFFFF);
        put(1'b1, OFS_CTRL_STATUS, 32'h00000001);
        k = 0;
        do begin
            idle(1);
            #1;
            k++;
        end while (!pulse && k < 50);
        if (!pulse) begin
            n_errors++;
            complete_run;
        end
        // Enable lands one clock after its write, then reload, then three steps
        check("wrap delay", 32'h00000005, 32'(k));
        check("current", DATA_ZERO, {8'h00, cur});
        check("wrap flag", 32'h00000001, {31'h0, flag});
        rd(OFS_CURRENT, 32'h00000003);
        rd(OFS_CTRL_STATUS, 32'h00010001);
        rd(OFS_CTRL_STATUS, 32'h00000001);
        put(1'b1, OFS_CTRL_STATUS, DATA_ZERO);
        rd(OFS_CTRL_STATUS, 32'h00010000);
        rd(OFS_CTRL_STATUS, DATA_ZERO);
        rd(OFS_CURRENT, 32'h00000003);
        // Random reload, random run length, then stop
        seed = xs(seed);
        r = seed[COUNT_W-1:0] | 24'h000100;
        seed = xs(seed);
        n = int'(seed[3:0]);
        put(1'b1, OFS_RELOAD, {8'h00, r});
        put(1'b1, OFS_CURRENT, seed);
        put(1'b1, OFS_CTRL_STATUS, 32'h00000001);
        idle(n);
        put(1'b1, OFS_CTRL_STATUS, DATA_ZERO);
        rd(OFS_CURRENT, {8'h00, r - COUNT_W'(n)});
        idle(9);
        #1;
        check("current", {8'h00, r - COUNT_W'(n)}, {8'h00, cur});
        check("enabled", DATA_ZERO, {31'h0, en});
        rd(OFS_CURRENT, {8'h00, r - COUNT_W'(n)});
        rd(OFS_RELOAD, {8'h00, r});
        rd(OFS_CTRL_STATUS, DATA_ZERO);
        // Zero reload parks the counter
        put(1'b1, OFS_RELOAD, DATA_ZERO);
        put(1'b1, OFS_CURRENT, DATA_ZERO);
        put(1'b1, OFS_CTRL_STATUS, 32'h00000001);
        idle(6);
        #1;
        check("enabled", 32'h00000001, {31'h0, en});
        check("wrap flag", DATA_ZERO, {31'h0, flag});
        check("wrap pulse", DATA_ZERO, {31'h0, pulse});
        rd(OFS_CURRENT, DATA_ZERO);
        rd(OFS_CTRL_STATUS, 32'h00000001);
        idle(3);
        complete_run;
    end
endmodule
`default_nettype wire
